/* fsrw_device.sv */
`default_nettype none
module fsrw_device
    import fsrw_pkg::*;
(
    // System clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // Serial link
    fsrw_link_if.device link,
    // Core side
    input wire logic i_busy,
    output logic [fsrw_pkg::FSRW_BYTE_W-1:0] o_status_one,
    output logic [fsrw_pkg::FSRW_BYTE_W-1:0] o_status_two,
    output logic o_array_protect,
    output logic o_write_enable,
    output logic o_reset_pulse
);
    import fsrw_pkg::*;

    // Serial clock domain state
    logic in_frame_r;           // Set after the first edge of a frame
    logic frame_tog_r;          // Flips once per clocked frame
    logic [2:0] bit_idx_r;      // Bit position within the current byte
    logic [1:0] bytes_r;        // Whole bytes seen, saturating at two
    logic [7:0] shift_r;        // Incoming bits
    logic [7:0] opcode_r;       // First byte of the frame
    logic [7:0] data_r;         // Second byte of the frame

    // Serial clock domain decode
    wire first_edge = ~in_frame_r;
    wire [2:0] idx_cur = first_edge ? 3'h0 : bit_idx_r;
    wire [1:0] bytes_cur = first_edge ? 2'h0 : bytes_r;
    wire [7:0] shift_nxt = {shift_r[6:0], link.si};
    wire byte_end = (idx_cur == 3'h7);
    wire [1:0] bytes_inc = (bytes_cur == 2'h2) ? 2'h2 : bytes_cur + 2'h1;

    // Frame marker, cleared whenever chip select is high
    always_ff @(posedge link.sck or posedge link.cs_n) begin
        if (link.cs_n) begin
            in_frame_r <= 1'b0;
        end else begin
            in_frame_r <= 1'b1;
        end
    end

    // Shift register on the rising serial clock edge
    always_ff @(posedge link.sck or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            frame_tog_r <= 1'b0;
            bit_idx_r <= 3'h0;
            bytes_r <= 2'h0;
            shift_r <= 8'h00;
        end else begin
            frame_tog_r <= frame_tog_r ^ first_edge;
            bit_idx_r <= idx_cur + 3'h1;
            bytes_r <= byte_end ? bytes_inc : bytes_cur;
            shift_r <= shift_nxt;
        end
    end

    // Keep the opcode and only the first data byte
    always_ff @(posedge link.sck or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            opcode_r <= 8'h00;
            data_r <= 8'h00;
        end else if (byte_end && bytes_cur == 2'h0) begin
            opcode_r <= shift_nxt;
        end else if (byte_end && bytes_cur == 2'h1) begin
            data_r <= shift_nxt;
        end
    end

    // Pins brought into the system clock domain
    logic [1:0] pins_s;         // {cs_n, wp_n} after two flip-flops
    logic cs_d_r;               // Delayed synchronised chip select
    logic seen_tog_r;           // Frame marker already consumed

    fsrw_sync2 #(
        .WIDTH(2),
        .RST_VAL(2'h3)
    ) u_pin_sync (
        .i_clk(i_mclk),
        .i_rst(i_sys_rst),
        .i_d({link.cs_n, link.wp_n}),
        .o_q(pins_s)
    );

    // Status bits
    logic reset_command_enable_r;               // Reset command enable
    logic lock_r;               // Protection lock
    logic prot_r;               // Array protect
    logic wel_r;                // Write enable latch

    // Release event; frame registers are quiet by then since the clock stopped
    wire cs_s = pins_s[1];
    wire wp_asserted = ~pins_s[0];
    wire release_evt = cs_s & ~cs_d_r;
    wire clocked = frame_tog_r ^ seen_tog_r;
    wire take = release_evt & clocked;
    wire op_done = (bytes_r != 2'h0);
    wire aligned = (bit_idx_r == 3'h0);
    wire got_data = (bytes_r == 2'h2) & aligned;

    // Opcode match of a clocked frame, shared by every command decode
    function automatic logic op_hit(
        input logic seen,
        input logic [7:0] op,
        input logic [7:0] want
    );
        return seen & (op == want);
    endfunction : op_hit

    // Command decode; a frame without a whole opcode decodes as nothing
    wire cmd_seen = take & op_done;
    wire is_wren = op_hit(cmd_seen, opcode_r, FSRW_OP_WREN);
    wire is_wrdi = op_hit(cmd_seen, opcode_r, FSRW_OP_WRDI);
    wire is_sw = op_hit(cmd_seen, opcode_r, FSRW_OP_STATUS_WRITE);
    wire is_b2 = op_hit(cmd_seen, opcode_r, FSRW_OP_BYTE2_WRITE);
    wire is_rst = op_hit(cmd_seen, opcode_r, FSRW_OP_RESET);

    // Status write and reset command acceptance
    wire frozen = lock_r & wp_asserted;
    wire clear_try = ~data_r[FSRW_D_LOCK_POS];
    wire sw_ignore = wp_asserted & lock_r & clear_try;
    wire sw_commit = is_sw & wel_r & got_data & ~sw_ignore & ~frozen;
    wire b2_commit = is_b2 & wel_r & got_data;
    wire reset_go = is_rst & aligned & reset_command_enable_r;

    // Next values
    wire lock_nxt = sw_commit ? data_r[FSRW_D_LOCK_POS] : lock_r;
    wire prot_nxt = sw_commit ? data_r[FSRW_D_PROT_POS] : prot_r;
    wire reset_command_enable_nxt = b2_commit ? data_r[FSRW_D_RESET_COMMAND_ENABLE_POS] : reset_command_enable_r;
    wire wel_set = is_wren & aligned;
    wire wel_clr = is_wrdi | (wel_r & (is_sw | is_b2)) | reset_go;
    wire wel_nxt = wel_set ? 1'b1 : (wel_clr ? 1'b0 : wel_r);

    // Byte images, each bit at its named position; the rest read 0
    wire [7:0] busy_img = 8'(i_busy) << FSRW_BUSY_POS;
    wire [7:0] lock_img = 8'(lock_nxt) << FSRW_S1_LOCK_POS;
    wire [7:0] wpp_img = 8'(pins_s[0]) << FSRW_S1_WPP_POS;
    wire [7:0] prot_img = 8'(prot_nxt) << FSRW_S1_PROT_POS;
    wire [7:0] wel_img = 8'(wel_nxt) << FSRW_S1_WEL_POS;
    wire [7:0] status_one_nxt = lock_img | wpp_img | prot_img | wel_img | busy_img;
    wire [7:0] status_two_nxt = (8'(reset_command_enable_nxt) << FSRW_S2_RESET_COMMAND_ENABLE_POS) | busy_img;

    // Release detection and frame consumption
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            cs_d_r <= 1'b1;
            seen_tog_r <= 1'b0;
        end else begin
            cs_d_r <= cs_s;
            seen_tog_r <= take ? frame_tog_r : seen_tog_r;
        end
    end

    // Status bits, committed only at release
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            reset_command_enable_r <= FSRW_RESET_COMMAND_ENABLE_RST;
            lock_r <= FSRW_LOCK_RST;
            prot_r <= FSRW_PROT_RST;
            wel_r <= FSRW_WEL_RST;
        end else begin
            reset_command_enable_r <= reset_command_enable_nxt;
            lock_r <= lock_nxt;
            prot_r <= prot_nxt;
            wel_r <= wel_nxt;
        end
    end

    // Registered outputs toward the core
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_status_one <= 8'h00;
            o_status_two <= 8'h00;
            o_array_protect <= FSRW_PROT_RST;
            o_write_enable <= FSRW_WEL_RST;
            o_reset_pulse <= 1'b0;
        end else begin
            o_status_one <= status_one_nxt;
            o_status_two <= status_two_nxt;
            o_array_protect <= prot_nxt;
            o_write_enable <= wel_nxt;
            o_reset_pulse <= reset_go;
        end
    end
endmodule : fsrw_device
`default_nettype wire

/* fsrw_pkg.sv */
`default_nettype none
package fsrw_pkg;
    // Byte and frame geometry
    localparam int FSRW_BYTE_W = 8;
    localparam int FSRW_NBITS_W = 5;
    localparam int FSRW_FRAME_W = 24;
    // Command opcodes
    localparam logic [7:0] FSRW_OP_WREN = 8'h06;
    localparam logic [7:0] FSRW_OP_WRDI = 8'h04;
    localparam logic [7:0] FSRW_OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] FSRW_OP_BYTE2_WRITE = 8'h31;
    localparam logic [7:0] FSRW_OP_RESET = 8'hf0;
    // Frame lengths in bits
    localparam logic [4:0] FSRW_OPCODE_BITS = 5'h08;
    localparam logic [4:0] FSRW_WRITE_BITS = 5'h10;
    // First status byte positions
    localparam int FSRW_S1_LOCK_POS = 7;
    localparam int FSRW_S1_WPP_POS = 4;
    localparam int FSRW_S1_PROT_POS = 2;
    localparam int FSRW_S1_WEL_POS = 1;
    // Second status byte positions
    localparam int FSRW_S2_RESET_COMMAND_ENABLE_POS = 4;
    localparam int FSRW_BUSY_POS = 0;
    // Data byte positions of the write commands
    localparam int FSRW_D_LOCK_POS = 7;
    localparam int FSRW_D_PROT_POS = 2;
    localparam int FSRW_D_RESET_COMMAND_ENABLE_POS = 4;
    // Reset values
    localparam logic FSRW_RESET_COMMAND_ENABLE_RST = 1'b0;
    localparam logic FSRW_LOCK_RST = 1'b0;
    localparam logic FSRW_PROT_RST = 1'b0;
    localparam logic FSRW_WEL_RST = 1'b0;
    // Host timing in i_mclk cycles
    localparam int FSRW_SCK_HALF = 2;
    localparam int FSRW_CS_GAP = 8;
    localparam int FSRW_CS_GAP_MIN = 4;
    localparam int FSRW_CNT_W = 8;
    // Host sequencer states
    typedef enum logic [2:0] {
        FSRW_IDLE = 3'b000,
        FSRW_LEAD = 3'b001,
        FSRW_HIGH = 3'b010,
        FSRW_LOW = 3'b011,
        FSRW_TRAIL = 3'b100,
        FSRW_GAP = 3'b101
    } fsrw_state_e;
endpackage : fsrw_pkg
`default_nettype wire

/* fsrw_link_if.sv */
`default_nettype none
interface fsrw_link_if;
    logic sck;   // Serial clock, idle low
    logic cs_n;  // Chip select, active low
    logic si;    // Serial data into the device
    logic wp_n;  // Write-protect pin, active low
    // Host drives every wire
    modport host (output sck, output cs_n, output si, output wp_n);
    // Device only listens
    modport device (input sck, input cs_n, input si, input wp_n);
endinterface : fsrw_link_if
`default_nettype wire

/* fsrw_sync2.sv */
`default_nettype none
module fsrw_sync2 #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Asynchronous input and synchronised output
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);
    logic [WIDTH-1:0] meta_r; // First stage, read only by the second

    // Two flip-flop synchroniser
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_r <= RST_VAL;
            o_q <= RST_VAL;
        end else begin
            meta_r <= i_d;
            o_q <= meta_r;
        end
    end
endmodule : fsrw_sync2
`default_nettype wire

/* fsrw_host.sv */
`default_nettype none
module fsrw_host
    import fsrw_pkg::*;
#(
    parameter int SCK_HALF = fsrw_pkg::FSRW_SCK_HALF,
    parameter int CS_GAP = fsrw_pkg::FSRW_CS_GAP
) (
    // System clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // Command port
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd_opcode,
    input wire logic [7:0] i_cmd_data,
    input wire logic [fsrw_pkg::FSRW_NBITS_W-1:0] i_cmd_nbits,
    output logic o_cmd_ready,
    output logic o_cmd_done,
    // Write-protect request
    input wire logic i_wp_assert,
    // Serial link
    fsrw_link_if.host link
);
    import fsrw_pkg::*;

    // Refuse timings the sequencer cannot serve
    if (SCK_HALF < 1 || SCK_HALF > 255) begin : g_half_chk
        $error("SCK_HALF out of range");
    end
    if (CS_GAP < FSRW_CS_GAP_MIN || CS_GAP > 255) begin : g_gap_chk
        $error("CS_GAP out of range");
    end

    localparam logic [FSRW_CNT_W-1:0] HALF_LD = FSRW_CNT_W'(SCK_HALF - 1);
    localparam logic [FSRW_CNT_W-1:0] GAP_LD = FSRW_CNT_W'(CS_GAP - 1);

    // Sequencer state
    fsrw_state_e state_r;
    logic [FSRW_CNT_W-1:0] cnt_r;          // Phase timer
    logic [1:0] frames_r;                  // Frames still to send
    logic [FSRW_FRAME_W-1:0] main_r;       // Command frame image
    logic [4:0] main_bits_r;               // Command frame length
    logic [FSRW_FRAME_W-1:0] shift_r;      // Bits being sent
    logic [4:0] left_r;                    // Bits still to send
    logic sck_r;
    logic cs_n_r;
    logic si_r;
    logic wp_n_r;

    // Command decode
    wire tick = (cnt_r == '0);
    wire accept = (state_r == FSRW_IDLE) & i_cmd_valid;
    wire needs_wel = (i_cmd_opcode == FSRW_OP_STATUS_WRITE) |
                     (i_cmd_opcode == FSRW_OP_BYTE2_WRITE);
    wire is_sw = (i_cmd_opcode == FSRW_OP_STATUS_WRITE);
    wire unlock = is_sw & ~i_cmd_data[FSRW_D_LOCK_POS];
    wire [4:0] bits_eff = needs_wel ? FSRW_WRITE_BITS : i_cmd_nbits;
    wire pre_frame = (frames_r == 2'h2);
    wire [FSRW_FRAME_W-1:0] wren_img = {FSRW_OP_WREN, 16'h0000};
    wire [FSRW_FRAME_W-1:0] next_img = pre_frame ? wren_img : main_r;
    wire [4:0] next_bits = pre_frame ? FSRW_OPCODE_BITS : main_bits_r;
    wire last_bit = (left_r == 5'h01);

    // Sequencer
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            state_r <= FSRW_IDLE;
            cnt_r <= '0;
            frames_r <= 2'h0;
            main_r <= '0;
            main_bits_r <= 5'h00;
            shift_r <= '0;
            left_r <= 5'h00;
            sck_r <= 1'b0;
            cs_n_r <= 1'b1;
            si_r <= 1'b0;
            wp_n_r <= 1'b1;
            o_cmd_ready <= 1'b0;
            o_cmd_done <= 1'b0;
        end else begin
            o_cmd_done <= 1'b0;
            case (state_r)
                FSRW_IDLE: begin
                    o_cmd_ready <= ~accept;
                    // Pin follows the request; a lock clear forces it released
                    wp_n_r <= ~i_wp_assert | (accept & unlock);
                    if (accept) begin
                        main_r <= {i_cmd_opcode, i_cmd_data, i_cmd_data};
                        main_bits_r <= bits_eff;
                        frames_r <= needs_wel ? 2'h2 : 2'h1;
                        cnt_r <= GAP_LD;
                        state_r <= FSRW_GAP;
                    end
                end
                FSRW_GAP: begin
                    if (!tick) begin
                        cnt_r <= cnt_r - 1'b1;
                    end else if (frames_r != 2'h0) begin
                        // Open the next frame with its first bit on the wire
                        frames_r <= frames_r - 2'h1;
                        shift_r <= next_img;
                        left_r <= next_bits;
                        si_r <= next_img[FSRW_FRAME_W-1];
                        cs_n_r <= 1'b0;
                        cnt_r <= HALF_LD;
                        state_r <= FSRW_LEAD;
                    end else begin
                        o_cmd_done <= 1'b1;
                        o_cmd_ready <= 1'b1;
                        state_r <= FSRW_IDLE;
                    end
                end
                FSRW_LEAD, FSRW_LOW: begin
                    if (!tick) begin
                        cnt_r <= cnt_r - 1'b1;
                    end else if (left_r == 5'h00) begin
                        cnt_r <= HALF_LD;
                        state_r <= FSRW_TRAIL;
                    end else begin
                        // Rising edge: the device samples here
                        sck_r <= 1'b1;
                        cnt_r <= HALF_LD;
                        state_r <= FSRW_HIGH;
                    end
                end
                FSRW_HIGH: begin
                    if (!tick) begin
                        cnt_r <= cnt_r - 1'b1;
                    end else begin
                        // Falling edge: present the next bit
                        sck_r <= 1'b0;
                        cnt_r <= HALF_LD;
                        left_r <= left_r - 5'h01;
                        shift_r <= {shift_r[FSRW_FRAME_W-2:0], 1'b0};
                        si_r <= shift_r[FSRW_FRAME_W-2];
                        state_r <= last_bit ? FSRW_TRAIL : FSRW_LOW;
                    end
                end
                FSRW_TRAIL: begin
                    if (!tick) begin
                        cnt_r <= cnt_r - 1'b1;
                    end else begin
                        // Release chip select; the device commits now
                        cs_n_r <= 1'b1;
                        cnt_r <= GAP_LD;
                        state_r <= FSRW_GAP;
                    end
                end
                default: begin
                    state_r <= FSRW_IDLE;
                end
            endcase
        end
    end

    // Link pins straight from flip-flops
    assign link.sck = sck_r;
    assign link.cs_n = cs_n_r;
    assign link.si = si_r;
    assign link.wp_n = wp_n_r;
endmodule : fsrw_host
`default_nettype wire

/* fsrw_checker.sv */
`default_nettype none
module fsrw_checker (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // Link wires
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_wp_n,
    // Device side
    input wire logic i_busy,
    input wire logic [7:0] i_status_one,
    input wire logic [7:0] i_status_two,
    input wire logic i_array_protect,
    input wire logic i_write_enable,
    input wire logic i_reset_pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_sys_rst);
    logic cs_q_r; // Chip select one cycle back
    logic [3:0] quiet_r; // Cycles since the last release
    // Count cycles since chip select rose, saturating
    always_ff @(posedge i_mclk) begin
        cs_q_r <= i_cs_n;
        if (i_sys_rst || (i_cs_n && !cs_q_r)) begin
            quiet_r <= 4'h0;
        end else if (quiet_r != 4'hf) begin
            quiet_r <= quiet_r + 4'h1;
        end
    end
    // Lock set with the pin asserted for a while
    sequence lock_held_s;
        (i_status_one[7] && !i_wp_n) [*8];
    endsequence
    // Enable bit stays set after a reset
    sequence enable_kept_s;
        i_status_two[4] [*4];
    endsequence
    idle_sck_a: assert property (i_cs_n |-> !i_sck)
        else $error("serial clock moved with chip select high");
    quiet_hold_a: assert property ((quiet_r > 4'h8) |->
        $stable(i_array_protect) && $stable(i_write_enable) && $stable(i_status_two[4]))
        else $error("status changed away from a release");
    one_map_a: assert property ((quiet_r > 4'h8) |->
        i_status_one[2:1] == {i_array_protect, i_write_enable}
        && i_status_one[6:5] == 2'h0 && !i_status_one[3])
        else $error("status byte one layout wrong");
    two_map_a: assert property (i_status_two[7:5] == 3'h0 && i_status_two[3:1] == 3'h0)
        else $error("status byte two reserved bit set");
    busy_copy_a: assert property (!$past(i_sys_rst) |->
        i_status_two[0] == $past(i_busy) && i_status_one[0] == $past(i_busy))
        else $error("busy flag not shown");
    pulse_gate_a: assert property (i_reset_pulse |-> i_status_two[4])
        else $error("reset carried out while disabled");
    pulse_one_a: assert property (i_reset_pulse |=> !i_reset_pulse)
        else $error("reset pulse longer than one cycle");
    enable_kept_a: assert property (i_reset_pulse |=> enable_kept_s)
        else $error("reset changed the enable bit");
    lock_freeze_a: assert property (lock_held_s |=> $stable(i_array_protect))
        else $error("array protect moved while frozen");
endmodule : fsrw_checker
`default_nettype wire

/* flash_status_register_write_tb.sv */
`default_nettype none
`define CHECK_EQ(what, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("unexpected %s: expected %h seen %h", what, exp, got); \
        end \
    end
module flash_status_register_write_tb
    import fsrw_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // Row: command, pin, expected status bytes and pulse
    typedef struct packed {
        logic [7:0] op;
        logic [7:0] data;
        logic [4:0] nbits;
        logic wp;
        logic [7:0] s1;
        logic [7:0] s2;
        logic pulse;
    } fsrw_row_s;
    localparam fsrw_row_s ROWS [13] = '{
        '{8'h01, 8'h84, 5'h10, 1'b0, 8'h94, 8'h00, 1'b0},
        '{8'h01, 8'h00, 5'h10, 1'b0, 8'h10, 8'h00, 1'b0},
        '{8'h01, 8'h7f, 5'h10, 1'b0, 8'h14, 8'h00, 1'b0},
        '{8'h31, 8'hff, 5'h10, 1'b0, 8'h14, 8'h10, 1'b0},
        '{8'hf0, 8'h00, 5'h08, 1'b0, 8'h14, 8'h10, 1'b1},
        '{8'h31, 8'hef, 5'h10, 1'b0, 8'h14, 8'h00, 1'b0},
        '{8'hf0, 8'h00, 5'h08, 1'b0, 8'h14, 8'h00, 1'b0},
        '{8'h06, 8'h00, 5'h08, 1'b0, 8'h16, 8'h00, 1'b0},
        '{8'h04, 8'h00, 5'h08, 1'b0, 8'h14, 8'h00, 1'b0},
        '{8'h01, 8'h84, 5'h10, 1'b1, 8'h84, 8'h00, 1'b0},
        '{8'h01, 8'h80, 5'h10, 1'b1, 8'h84, 8'h00, 1'b0},
        '{8'h01, 8'h00, 5'h10, 1'b1, 8'h00, 8'h00, 1'b0},
        '{8'h01, 8'h04, 5'h10, 1'b0, 8'h14, 8'h00, 1'b0}};
    logic i_mclk = 1'b0;
    logic i_sys_rst = 1'b0; // Raised at 1 ns so the serial-side clears see an edge
    logic i_busy = 1'b0;
    logic cmd_valid = 1'b0;
    logic [7:0] cmd_opcode = 8'h00;
    logic [7:0] cmd_data = 8'h00;
    logic [4:0] cmd_nbits = 5'h00;
    logic wp_assert = 1'b0;
    logic cmd_ready, cmd_done, prot, write_enable_latch, rpulse, welb;
    logic [7:0] s1, s2, s1b;
    logic pulse_seen = 1'b0; // Reset pulse caught during a command
    logic [15:0] mon_sh = 16'h0; // Bits seen on the wire
    logic [15:0] mon_frame = 16'h0;
    logic [4:0] mon_cnt = 5'h0;
    logic [4:0] mon_len = 5'h0;
    logic [4:0] mon_base = 5'h0; // Bit count at the last release
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    fsrw_link_if link ();
    fsrw_link_if link_far (); // Driven by the bench as a faulty host
    fsrw_host i_fsrw_host (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_cmd_valid(cmd_valid),
        .i_cmd_opcode(cmd_opcode), .i_cmd_data(cmd_data), .i_cmd_nbits(cmd_nbits),
        .o_cmd_ready(cmd_ready), .o_cmd_done(cmd_done), .i_wp_assert(wp_assert),
        .link(link.host));
    fsrw_device i_fsrw_device (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .link(link.device),
        .i_busy(i_busy), .o_status_one(s1), .o_status_two(s2), .o_array_protect(prot),
        .o_write_enable(write_enable_latch), .o_reset_pulse(rpulse));
    fsrw_device i_fsrw_device_far (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .link(link_far.device), .i_busy(i_busy), .o_status_one(s1b), .o_status_two(),
        .o_array_protect(), .o_write_enable(welb), .o_reset_pulse());
    fsrw_checker i_fsrw_checker (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_sck(link.sck),
        .i_cs_n(link.cs_n), .i_wp_n(link.wp_n), .i_busy(i_busy), .i_status_one(s1),
        .i_status_two(s2), .i_array_protect(prot), .i_write_enable(write_enable_latch),
        .i_reset_pulse(rpulse));
    // System clock
    initial begin
        forever #4 i_mclk = ~i_mclk;
    end
    // Wire monitor: shift in on rising serial clock
    always @(posedge link.sck) begin
        if (!link.cs_n) begin
            mon_sh <= {mon_sh[14:0], link.si};
            mon_cnt <= mon_cnt + 5'h1;
        end
    end
    // Keep the finished frame at release
    always @(posedge link.cs_n) begin
        mon_frame <= mon_sh;
        mon_len <= mon_cnt - mon_base;
        mon_base <= mon_cnt;
    end
    // Catch reset pulses; cut a hang short
    always @(posedge i_mclk) begin
        cycles++;
        if (cmd_valid === 1'b1) begin
            pulse_seen <= 1'b0;
        end else if (rpulse === 1'b1) begin
            pulse_seen <= 1'b1;
        end
        if (cycles == 10000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    // One command through the host, then let the device settle
    task automatic run_cmd(input fsrw_row_s r);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 50) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        `CHECK_EQ("ready", 1'b1, cmd_ready)
        wp_assert = r.wp;
        cmd_opcode = r.op;
        cmd_data = r.data;
        cmd_nbits = r.nbits;
        cmd_valid = 1'b1;
        @(posedge i_mclk);
        #1;
        cmd_valid = 1'b0;
        `CHECK_EQ("ready after accept", 1'b0, cmd_ready)
        n = 0;
        while (cmd_done !== 1'b1 && n < 1000) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        `CHECK_EQ("done", 1'b1, cmd_done)
        repeat (6) @(posedge i_mclk);
        #1;
    endtask : run_cmd
    // Bit-banged frame on the second link, 12 ns serial clock
    task automatic send_far(input logic [23:0] bits, input int n);
        @(posedge i_mclk);
        #1;
        link_far.cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            link_far.si = bits[23-i];
            #6 link_far.sck = 1'b1;
            #6 link_far.sck = 1'b0;
        end
        #6 link_far.cs_n = 1'b1;
        link_far.si = ~link_far.si;
        repeat (10) @(posedge i_mclk);
        #1;
    endtask : send_far
    // Print counts and verdict
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test
    // Main sequence
    initial begin
        #1;
        i_sys_rst = 1'b1;
        link_far.sck = 1'b0;
        link_far.cs_n = 1'b1;
        link_far.si = 1'b0;
        link_far.wp_n = 1'b1;
        repeat (20) @(posedge i_mclk);
        #1;
        i_sys_rst = 1'b0;
        foreach (ROWS[k]) begin
            run_cmd(ROWS[k]);
            `CHECK_EQ("status one", ROWS[k].s1, s1)
            `CHECK_EQ("status two", ROWS[k].s2, s2)
            `CHECK_EQ("reset pulse", ROWS[k].pulse, pulse_seen)
            `CHECK_EQ("protect and latch", ROWS[k].s1[2:1], {prot, write_enable_latch})
            `CHECK_EQ("wire frame", {ROWS[k].nbits, ROWS[k].nbits == 5'h10 ? ROWS[k].data
                : ROWS[k].op}, {mon_len, mon_frame[7:0]})
        end
        i_busy = 1'b1;
        repeat (2) @(posedge i_mclk);
        #1;
        `CHECK_EQ("busy", 2'b11, {s1[0], s2[0]})
        i_busy = 1'b0;
        send_far({FSRW_OP_WREN, 16'h0}, 8);
        `CHECK_EQ("far latch", 1'b1, welb)
        send_far({FSRW_OP_STATUS_WRITE, 8'h84, 8'h00}, 24);
        `CHECK_EQ("far extra byte", 8'h94, s1b)
        send_far({FSRW_OP_WREN, 16'h0}, 8);
        send_far({FSRW_OP_STATUS_WRITE, 16'h0}, 12);
        `CHECK_EQ("far misaligned", 8'h94, s1b)
        send_far({FSRW_OP_WREN, 16'h0}, 8);
        send_far({FSRW_OP_STATUS_WRITE, 16'h0}, 4);
        `CHECK_EQ("far short opcode", 8'h96, s1b)
        link_far.wp_n = 1'b0;
        send_far({FSRW_OP_STATUS_WRITE, 16'h0}, 16);
        `CHECK_EQ("far pin clear", 8'h84, s1b)
        link_far.wp_n = 1'b1;
        send_far({FSRW_OP_STATUS_WRITE, 16'h0}, 16);
        `CHECK_EQ("far no latch", 8'h94, s1b)
        i_sys_rst = 1'b1;
        repeat (20) @(posedge i_mclk);
        #1;
        `CHECK_EQ("in reset", 16'h0, {s1, s2})
        i_sys_rst = 1'b0;
        repeat (6) @(posedge i_mclk);
        #1;
        `CHECK_EQ("after reset", {8'h10, 8'h00, 2'b00}, {s1, s2, prot, write_enable_latch})
        end_of_test();
    end
endmodule : flash_status_register_write_tb
`default_nettype wire
